// ===== inc/mfr_defs.svh
// Offsets, field positions, reset values and routing codes of the terminal routing register
`ifndef MFR_DEFS_SVH
`define MFR_DEFS_SVH

`define MFR_ROUTE_OFFSET 8'h8c
`define MFR_ROUTE_RESET 32'h0000_0000
`define MFR_ROUTE_WIDTH 28
`define MFR_FUNC_LAST 3'h1

`define MFR_T6_LSB 24
`define MFR_T5_LSB 20
`define MFR_T4_LSB 16
`define MFR_T3_LSB 12
`define MFR_T2_LSB 8
`define MFR_FIELD_W 4

`define MFR_CODE_DEFAULT 4'h0
`define MFR_CODE_ALT1 4'h1
`define MFR_CODE_ALT2 4'h2
`define MFR_CODE_ZV_STATUS 4'h6
`define MFR_CODE_ZV_F1SEL 4'h7
`define MFR_CODE_AUDIO 4'h8
`define MFR_CODE_MID_LED 4'hc
`define MFR_CODE_ANY_LED 4'hd
`define MFR_CODE_EVENT 4'he

`endif

// ===== inc/mfr_pkg.sv
// Types of the terminal routing block
package mfr_pkg;

    typedef struct packed {
        logic [15:0] isa_irq;
        logic clkrun_out;
        logic clkrun_oe;
        logic serial_interrupt_stream_out;
        logic serial_interrupt_stream_oe;
        logic general_output_3;
        logic general_output_4;
        logic zoom_video_status;
        logic zoom_video_func1_select;
        logic card_audio_pwm;
        logic socket0_activity_led;
        logic either_socket_activity_led;
        logic general_event_out;
        logic ring_indicate_out;
        logic serial_clk_out;
        logic serial_clk_oe;
    } mfr_src_t;

    typedef struct packed {
        logic [27:0] route;
        logic [31:0] rdata;
        logic ack;
        logic [3:0] pin_out;
        logic [3:0] pin_oe;
        logic term1_out;
        logic term1_oe;
        logic term2_out;
        logic term2_oe;
        logic general_input_3;
        logic general_input_4;
        logic central_dma_grant;
        logic pci_lock;
        logic clkrun_in;
        logic serial_interrupt_stream_in;
        logic serial_data_in;
        logic serial_clk_in;
    } mfr_state_t;

endpackage

// ===== inc/mfr_route_if.sv
// Selection codes and sources in, terminal drive out
`timescale 1ns/1ps
interface mfr_route_if;
    import mfr_pkg::*;
    logic [3:0][3:0] sel;
    logic serial_mode;
    mfr_src_t src;
    logic [3:0] res_out;
    logic [3:0] res_oe;

    modport decoder (
        input sel,
        input serial_mode,
        input src,
        output res_out,
        output res_oe
    );
    modport owner (
        output sel,
        output serial_mode,
        output src,
        input res_out,
        input res_oe
    );
endinterface

// ===== verilog/mfr_term_decode.sv
// Output decode for terminals 3 to 6
`timescale 1ns/1ps
`include "mfr_defs.svh"
module mfr_term_decode
    import mfr_pkg::*;
(
    // Routing bundle
    mfr_route_if.decoder rif
);

    // Returns {oe, out} for one terminal
    function automatic logic [1:0] route_one(input int idx, input logic [3:0] code, input mfr_src_t s,
                                             input logic ser);
        logic [1:0] r;
        r = 2'b00;
        if (idx == 3 || idx == 6) begin
            if (code == `MFR_CODE_DEFAULT) begin
                r = 2'b00;
            end else if (code == `MFR_CODE_ALT1) begin
                if (idx == 6) begin
                    r = {s.clkrun_oe, s.clkrun_out};
                end else begin
                    r = {s.serial_interrupt_stream_oe, s.serial_interrupt_stream_out};
                end
            end else begin
                r = {1'b1, s.isa_irq[code]};
            end
        end else begin
            case (code)
                `MFR_CODE_DEFAULT: r = 2'b00;
                `MFR_CODE_ALT1: r = {1'b1, (idx == 4) ? s.general_output_3 : s.general_output_4};
                `MFR_CODE_ALT2: r = 2'b00;
                `MFR_CODE_ZV_STATUS: r = {1'b1, s.zoom_video_status};
                `MFR_CODE_ZV_F1SEL: r = {1'b1, s.zoom_video_func1_select};
                `MFR_CODE_AUDIO: r = {1'b1, s.card_audio_pwm};
                `MFR_CODE_MID_LED: r = {1'b1, (idx == 4) ? s.ring_indicate_out : s.socket0_activity_led};
                `MFR_CODE_ANY_LED: r = {1'b1, s.either_socket_activity_led};
                `MFR_CODE_EVENT: r = {1'b1, s.general_event_out};
                default: r = {1'b1, s.isa_irq[code]};
            endcase
            if (idx == 4 && ser) begin
                r = {s.serial_clk_oe, s.serial_clk_out};
            end
        end
        return r;
    endfunction

    // One decoder per terminal
    for (genvar g = 0; g < 4; g++) begin : g_term
        assign {rif.res_oe[g], rif.res_out[g]} = route_one(g + 3, rif.sel[g], rif.src, rif.serial_mode);
    end

endmodule

// ===== verilog/mfr_pin_route.sv
// Terminal routing register and terminal multiplexer
//
// Functional notes
// - Bits 31 to 28 read zero, ignore writes
// - Same register at 8Ch in both functions
// - Register resets to all zeros
// - Serial EEPROM value may replace reset value
// - Terminal 6: zero hi-Z, one clock-run
// - Terminal 6 codes 2-15 drive ISA IRQ
// - Terminal 5: input 4, output 4, DMA grant
// - Terminals 5,4: IRQ3-5, zoom video, audio PWM
// - Terminals 5,4: IRQ9-11, IRQ15
// - Terminal 5: either-socket LED, general event
// - Terminal 4: input 3, output 3, PCI lock
// - Serial mode puts bus clock on terminal 4
// - Terminal 4: ring indicate, LED, general event
// - Terminal 3: zero hi-Z, one serial interrupts
// - Terminal 3 codes 2-15 drive ISA IRQ
// - Serial mode puts bus data on terminal 1
// - Terminal 2 code two drives DMA request
`timescale 1ns/1ps
`include "mfr_defs.svh"
module mfr_pin_route
    import mfr_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Configuration access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [2:0] cfg_func,
    input wire logic [7:0] cfg_offset,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    // Serial EEPROM load
    input wire logic eeprom_load,
    input wire logic [31:0] eeprom_data,
    // Serial bus mode strap
    input wire logic serial_latch_n,
    // Internal sources
    input wire logic [15:0] isa_irq,
    input wire logic clkrun_out,
    input wire logic clkrun_oe,
    input wire logic serial_interrupt_stream_out,
    input wire logic serial_interrupt_stream_oe,
    input wire logic general_output_3,
    input wire logic general_output_4,
    input wire logic zoom_video_status,
    input wire logic zoom_video_func1_select,
    input wire logic card_audio_pwm,
    input wire logic socket0_activity_led,
    input wire logic either_socket_activity_led,
    input wire logic general_event_out,
    input wire logic ring_indicate_out,
    input wire logic serial_clk_out,
    input wire logic serial_clk_oe,
    input wire logic serial_data_out,
    input wire logic serial_data_oe,
    input wire logic central_dma_request,
    // Internal sinks
    output logic general_input_3,
    output logic general_input_4,
    output logic central_dma_grant,
    output logic pci_lock,
    output logic clkrun_in,
    output logic serial_interrupt_stream_in,
    output logic serial_data_in,
    output logic serial_clk_in,
    // Terminals 3 to 6, bit 0 is terminal 3
    input wire logic [3:0] term_in,
    output logic [3:0] term_out,
    output logic [3:0] term_oe,
    // Terminal 1
    input wire logic term1_in,
    output logic term1_out,
    output logic term1_oe,
    // Terminal 2
    output logic term2_out,
    output logic term2_oe
);

    localparam logic [31:0] ROUTE_RESET = `MFR_ROUTE_RESET;
    localparam logic [7:0] ROUTE_OFFSET = `MFR_ROUTE_OFFSET;
    localparam logic [2:0] FUNC_LAST = `MFR_FUNC_LAST;

    mfr_state_t st;
    mfr_state_t next_st;
    mfr_route_if rif ();

    logic serial_mode;
    logic hit;
    logic [31:0] wr_word;
    logic [3:0] sel3;
    logic [3:0] sel4;
    logic [3:0] sel5;
    logic [3:0] sel6;
    logic [3:0] sel2;

    // Field extraction
    assign sel6 = st.route[`MFR_T6_LSB +: `MFR_FIELD_W];
    assign sel5 = st.route[`MFR_T5_LSB +: `MFR_FIELD_W];
    assign sel4 = st.route[`MFR_T4_LSB +: `MFR_FIELD_W];
    assign sel3 = st.route[`MFR_T3_LSB +: `MFR_FIELD_W];
    assign sel2 = st.route[`MFR_T2_LSB +: `MFR_FIELD_W];
    assign serial_mode = ~serial_latch_n;

    // Decoder hookup
    assign rif.sel[0] = sel3;
    assign rif.sel[1] = sel4;
    assign rif.sel[2] = sel5;
    assign rif.sel[3] = sel6;
    assign rif.serial_mode = serial_mode;
    assign rif.src.isa_irq = isa_irq;
    assign rif.src.clkrun_out = clkrun_out;
    assign rif.src.clkrun_oe = clkrun_oe;
    assign rif.src.serial_interrupt_stream_out = serial_interrupt_stream_out;
    assign rif.src.serial_interrupt_stream_oe = serial_interrupt_stream_oe;
    assign rif.src.general_output_3 = general_output_3;
    assign rif.src.general_output_4 = general_output_4;
    assign rif.src.zoom_video_status = zoom_video_status;
    assign rif.src.zoom_video_func1_select = zoom_video_func1_select;
    assign rif.src.card_audio_pwm = card_audio_pwm;
    assign rif.src.socket0_activity_led = socket0_activity_led;
    assign rif.src.either_socket_activity_led = either_socket_activity_led;
    assign rif.src.general_event_out = general_event_out;
    assign rif.src.ring_indicate_out = ring_indicate_out;
    assign rif.src.serial_clk_out = serial_clk_out;
    assign rif.src.serial_clk_oe = serial_clk_oe;

    mfr_term_decode u_decode (
        .rif(rif.decoder)
    );

    // Input steering enables
    logic take_input_3;
    logic take_lock;
    logic take_input_4;
    logic take_grant;
    logic take_clkrun;
    logic take_irq_stream;
    assign take_input_3 = (sel4 == `MFR_CODE_DEFAULT) && !serial_mode;
    assign take_lock = (sel4 == `MFR_CODE_ALT2) && !serial_mode;
    assign take_input_4 = (sel5 == `MFR_CODE_DEFAULT);
    assign take_grant = (sel5 == `MFR_CODE_ALT2);
    assign take_clkrun = (sel6 == `MFR_CODE_ALT1);
    assign take_irq_stream = (sel3 == `MFR_CODE_ALT1);

    // Terminal 2 request enable
    logic drive_dma_request;
    assign drive_dma_request = (sel2 == `MFR_CODE_ALT2);

    // Next state
    always_comb begin
        next_st = st;
        next_st.ack = cfg_rd | cfg_wr;
        hit = (cfg_func <= FUNC_LAST) && (cfg_offset == ROUTE_OFFSET);
        if (eeprom_load) begin
            next_st.route = eeprom_data[`MFR_ROUTE_WIDTH-1:0];
        end
        wr_word = {4'h0, next_st.route};
        for (int b = 0; b < 4; b++) begin
            if (cfg_wr && hit && cfg_byte_en[b]) begin
                wr_word[b*8 +: 8] = cfg_wdata[b*8 +: 8];
            end
        end
        next_st.route = wr_word[`MFR_ROUTE_WIDTH-1:0];
        if (cfg_rd) begin
            next_st.rdata = hit ? {4'h0, st.route} : 32'h0000_0000;
        end
        // Terminals 3 to 6
        next_st.pin_out = rif.res_out;
        next_st.pin_oe = rif.res_oe;
        // Terminal 1 serial data
        next_st.term1_out = serial_mode ? serial_data_out : 1'b0;
        next_st.term1_oe = serial_mode ? serial_data_oe : 1'b0;
        // Terminal 2 DMA request
        next_st.term2_out = drive_dma_request & central_dma_request;
        next_st.term2_oe = drive_dma_request;
        // Inputs steered to internal sinks
        next_st.general_input_3 = take_input_3 & term_in[1];
        next_st.pci_lock = take_lock & term_in[1];
        next_st.serial_clk_in = serial_mode ? term_in[1] : 1'b1;
        next_st.general_input_4 = take_input_4 & term_in[2];
        next_st.central_dma_grant = take_grant & term_in[2];
        next_st.clkrun_in = take_clkrun & term_in[3];
        next_st.serial_interrupt_stream_in = take_irq_stream & term_in[0];
        next_st.serial_data_in = serial_mode ? term1_in : 1'b1;
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st <= '0;
            st.route <= ROUTE_RESET[`MFR_ROUTE_WIDTH-1:0];
            st.serial_clk_in <= 1'b1;
            st.serial_data_in <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign cfg_rdata = st.rdata;
    assign cfg_ack = st.ack;
    assign term_out = st.pin_out;
    assign term_oe = st.pin_oe;
    assign term1_out = st.term1_out;
    assign term1_oe = st.term1_oe;
    assign term2_out = st.term2_out;
    assign term2_oe = st.term2_oe;
    assign general_input_3 = st.general_input_3;
    assign general_input_4 = st.general_input_4;
    assign central_dma_grant = st.central_dma_grant;
    assign pci_lock = st.pci_lock;
    assign clkrun_in = st.clkrun_in;
    assign serial_interrupt_stream_in = st.serial_interrupt_stream_in;
    assign serial_data_in = st.serial_data_in;
    assign serial_clk_in = st.serial_clk_in;

endmodule

// ===== sim/mfr_pin_route_checker.sv
// Port assertions for the terminal routing block
`timescale 1ns/1ps
module mfr_pin_route_checker (
    // Clock, reset and configuration
    input wire logic ref_clk, sys_rst, cfg_wr, cfg_rd, cfg_ack, eeprom_load,
    input wire logic [2:0] cfg_func,
    input wire logic [7:0] cfg_offset,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata, cfg_rdata, eeprom_data,
    // Serial bus and terminals
    input wire logic serial_latch_n, serial_clk_out, serial_clk_oe, serial_data_oe,
    input wire logic serial_data_in, term1_in, term1_oe, term2_oe,
    input wire logic [3:0] term_out, term_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire hit = cfg_func <= 3'h1 && cfg_offset == 8'h8c;
    sequence s_full_wr;
        cfg_wr && hit && cfg_byte_en == 4'hf && !eeprom_load ##1 !cfg_wr && !eeprom_load;
    endsequence
    sequence s_load;
        eeprom_load && !cfg_wr ##1 !cfg_wr && !eeprom_load;
    endsequence
    a_ack_every_access: assert property ((cfg_wr || cfg_rd) |=> cfg_ack)
        else $error("ack missing");
    a_ack_only_access: assert property (!(cfg_wr || cfg_rd) |=> !cfg_ack)
        else $error("stray ack");
    a_rsvd_read_zero: assert property (cfg_rdata[31:28] == 4'h0)
        else $error("top bits nonzero");
    a_miss_read_zero: assert property (cfg_rd && !hit |=> cfg_rdata == 32'h0)
        else $error("miss returned data");
    a_write_read_back: assert property (s_full_wr ##1 cfg_rd && hit
        |=> cfg_rdata == ($past(cfg_wdata, 3) & 32'h0fffffff)) else $error("readback wrong");
    a_load_read_back: assert property (s_load ##1 cfg_rd && hit
        |=> cfg_rdata == ($past(eeprom_data, 3) & 32'h0fffffff)) else $error("load wrong");
    a_reset_clears: assert property (@(posedge ref_clk) disable iff (1'b0)
        sys_rst |=> term_oe == 4'h0 && cfg_rdata == 32'h0 && !cfg_ack) else $error("reset state");
    a_t6_drive_code: assert property (s_full_wr |=> $past(cfg_wdata[27:24], 2) == 4'h1
        || term_oe[3] == ($past(cfg_wdata[27:24], 2) != 4'h0)) else $error("terminal 6 drive");
    a_t3_drive_code: assert property (s_full_wr |=> $past(cfg_wdata[15:12], 2) == 4'h1
        || term_oe[0] == ($past(cfg_wdata[15:12], 2) != 4'h0)) else $error("terminal 3 drive");
    a_t2_dma_request: assert property (s_full_wr |=> term2_oe == ($past(cfg_wdata[11:8], 2) == 4'h2))
        else $error("terminal 2 drive");
    a_serial_clk_pin: assert property (!serial_latch_n |=> term_oe[1] == $past(serial_clk_oe)
        && (!term_oe[1] || term_out[1] == $past(serial_clk_out))) else $error("serial clock pin");
    a_serial_data_pin: assert property (!serial_latch_n |=> term1_oe == $past(serial_data_oe)
        && serial_data_in == $past(term1_in)) else $error("serial data pin");
    a_parallel_idle: assert property (serial_latch_n |=> !term1_oe && serial_data_in)
        else $error("terminal 1 busy");
endmodule

bind mfr_pin_route mfr_pin_route_checker u_chk (.ref_clk, .sys_rst, .cfg_wr, .cfg_rd, .cfg_ack, .eeprom_load,
    .cfg_func, .cfg_offset, .cfg_byte_en, .cfg_wdata, .cfg_rdata, .eeprom_data, .serial_latch_n, .serial_clk_out,
    .serial_clk_oe, .serial_data_oe, .serial_data_in, .term1_in, .term1_oe, .term2_oe, .term_out, .term_oe);

// ===== sim/mfr_board_model.sv
// Board-side system logic: internal sources and terminal wires
`timescale 1ns/1ps
module mfr_board_model
    import mfr_pkg::*;
(
    // Clock and stimulus word
    input wire logic ref_clk,
    input wire logic step,
    input wire logic [63:0] rnd,
    // Sources toward the router
    output mfr_src_t src,
    output logic serial_data_out, serial_data_oe, central_dma_request,
    // Terminal wires
    input wire logic [3:0] term_out, term_oe,
    input wire logic term1_out, term1_oe,
    output logic [3:0] term_in,
    output logic term1_in
);
    logic [3:0] ext, ext_oe;
    logic ext1, ext1_oe;
    initial {src, serial_data_out, serial_data_oe, central_dma_request, ext, ext_oe, ext1, ext1_oe} = '0;
    // New levels at the falling edge after a step
    always @(negedge ref_clk) begin
        if (step) begin
            {src, serial_data_out, serial_data_oe, central_dma_request, ext, ext_oe, ext1, ext1_oe} <= rnd[43:0];
        end
    end
    // Pull-up where nobody drives; the board backs off where the router drives
    assign term_in = (term_oe & term_out) | (~term_oe & ext_oe & ext) | (~term_oe & ~ext_oe);
    assign term1_in = term1_oe ? term1_out : (ext1_oe ? ext1 : 1'b1);
endmodule

// ===== sim/test_mfr_pin_route.sv
// Self-checking bench for the terminal routing block
`timescale 1ns/1ps
module test_mfr_pin_route
    import mfr_pkg::*;
();
    logic ref_clk = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, eeprom_load = 1'b0;
    logic serial_latch_n = 1'b1, step = 1'b0;
    logic [2:0] cfg_func = 3'h0;
    logic [7:0] cfg_offset = 8'h8c;
    logic [3:0] cfg_byte_en = 4'hf;
    logic [31:0] cfg_wdata = 32'h0, eeprom_data = 32'h0, route = 32'h0, cfg_rdata, rd, got;
    logic [63:0] rnd = 64'h0;
    logic [1:0] e;
    logic cfg_ack, term1_in, term1_out, term1_oe, term2_out, term2_oe;
    logic serial_data_out, serial_data_oe, central_dma_request, serial_data_in, serial_clk_in;
    logic general_input_3, general_input_4, central_dma_grant, pci_lock, clkrun_in, serial_interrupt_stream_in;
    logic [3:0] term_in, term_out, term_oe;
    mfr_src_t src;
    int seed = 69, fail_count = 0, n_compared = 0, n, t;

    always #5 ref_clk = ~ref_clk;

    mfr_board_model board (.ref_clk, .step, .rnd, .src, .serial_data_out, .serial_data_oe, .central_dma_request,
        .term_out, .term_oe, .term1_out, .term1_oe, .term_in, .term1_in);
    mfr_pin_route DUT (.ref_clk, .sys_rst, .cfg_wr, .cfg_rd, .cfg_func, .cfg_offset, .cfg_byte_en, .cfg_wdata,
        .cfg_rdata, .cfg_ack, .eeprom_load, .eeprom_data, .serial_latch_n, .isa_irq(src.isa_irq),
        .clkrun_out(src.clkrun_out), .clkrun_oe(src.clkrun_oe), .general_output_3(src.general_output_3),
        .serial_interrupt_stream_out(src.serial_interrupt_stream_out), .general_output_4(src.general_output_4),
        .serial_interrupt_stream_oe(src.serial_interrupt_stream_oe), .zoom_video_status(src.zoom_video_status),
        .zoom_video_func1_select(src.zoom_video_func1_select), .card_audio_pwm(src.card_audio_pwm),
        .socket0_activity_led(src.socket0_activity_led), .general_event_out(src.general_event_out),
        .either_socket_activity_led(src.either_socket_activity_led), .ring_indicate_out(src.ring_indicate_out),
        .serial_clk_out(src.serial_clk_out), .serial_clk_oe(src.serial_clk_oe), .serial_data_out,
        .serial_data_oe, .central_dma_request, .general_input_3, .general_input_4, .central_dma_grant, .pci_lock,
        .clkrun_in, .serial_interrupt_stream_in, .serial_data_in, .serial_clk_in, .term_in, .term_out, .term_oe,
        .term1_in, .term1_out, .term1_oe, .term2_out, .term2_oe);

    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    // One configuration access, read data lands in rd
    task automatic access(input logic wr, input logic [2:0] fn, input logic [7:0] off, input logic [3:0] be,
        input logic [31:0] wd);
        int i;
        @(negedge ref_clk);
        {cfg_wr, cfg_rd, cfg_func, cfg_offset, cfg_byte_en, cfg_wdata} = {wr, !wr, fn, off, be, wd};
        @(negedge ref_clk);
        {cfg_wr, cfg_rd} = 2'b00;
        for (i = 0; i < 4 && cfg_ack !== 1'b1; i++) @(negedge ref_clk);
        if (i == 4) begin
            fail_count++;
            stop_test();
        end
        rd = cfg_rdata;
    endtask

    // Expected drive {oe, out} of terminal t+3 for field code c
    function automatic logic [1:0] exp_pin(input logic [3:0] c, input int t);
        logic [15:0] lv;
        lv = {src.isa_irq[15], src.general_event_out, src.either_socket_activity_led,
            t == 1 ? src.ring_indicate_out : src.socket0_activity_led, src.isa_irq[11:9], src.card_audio_pwm,
            src.zoom_video_func1_select, src.zoom_video_status, src.isa_irq[5:3], 1'b0,
            t == 1 ? src.general_output_3 : src.general_output_4, 1'b0};
        if (t == 1 && !serial_latch_n) return {src.serial_clk_oe, src.serial_clk_out};
        if (c == 4'h0) return 2'b00;
        if (t == 0 && c == 4'h1) return {src.serial_interrupt_stream_oe, src.serial_interrupt_stream_out};
        if (t == 3 && c == 4'h1) return {src.clkrun_oe, src.clkrun_out};
        if (t == 0 || t == 3) return {1'b1, src.isa_irq[c]};
        return {c != 4'h2, lv[c]};
    endfunction

    function automatic logic [7:0] exp_sinks();
        logic s;
        s = serial_latch_n;
        return {route[19:16] == 4'h0 && s && term_in[1], route[23:20] == 4'h0 && term_in[2],
            route[23:20] == 4'h2 && term_in[2], route[19:16] == 4'h2 && s && term_in[1],
            route[27:24] == 4'h1 && term_in[3], route[15:12] == 4'h1 && term_in[0], s || term1_in, s || term_in[1]};
    endfunction

    initial begin
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        check(32'(term_oe), 32'h0);
        access(1'b0, 3'h1, 8'h8c, 4'h0, 32'h0);
        check(rd, 32'h0);
        access(1'b1, 3'h1, 8'h8c, 4'hf, 32'hffff_ffff);
        access(1'b0, 3'h0, 8'h8c, 4'h0, 32'h0);
        check(rd, 32'h0fff_ffff);
        access(1'b1, 3'h2, 8'h8c, 4'hf, 32'h0);
        access(1'b1, 3'h0, 8'h90, 4'hf, 32'h0);
        access(1'b1, 3'h0, 8'h8c, 4'h4, 32'h0);
        access(1'b0, 3'h0, 8'h8c, 4'h0, 32'h0);
        check(rd, 32'h0f00_ffff);
        access(1'b0, 3'h5, 8'h8c, 4'h0, 32'h0);
        check(rd, 32'h0);
        @(negedge ref_clk);
        {eeprom_load, eeprom_data} = {1'b1, 32'hf123_4567};
        @(negedge ref_clk);
        eeprom_load = 1'b0;
        access(1'b0, 3'h1, 8'h8c, 4'h0, 32'h0);
        check(rd, 32'h0123_4567);
        // Every code on all fields first, then random routings
        for (n = 0; n < 216; n++) begin
            route = (n < 16) ? {4'h0, {7{n[3:0]}}} : ($random(seed) & 32'h0fff_ffff);
            access(1'b1, {2'b00, n[0]}, 8'h8c, 4'hf, route);
            serial_latch_n <= n[2:0] != 3'h5;
            rnd <= {$random(seed), $random(seed)};
            step <= 1'b1;
            @(negedge ref_clk);
            step <= 1'b0;
            repeat (3) @(negedge ref_clk);
            for (t = 0; t < 4; t++) begin
                e = exp_pin(route[4 * t + 12 +: 4], t);
                got = 32'({term_oe[t], term_oe[t] & term_out[t]});
                check(got, 32'({e[1], e[1] & e[0]}));
            end
            got = 32'({general_input_3, general_input_4, central_dma_grant, pci_lock, clkrun_in,
                serial_interrupt_stream_in, serial_data_in, serial_clk_in});
            check(got, 32'(exp_sinks()));
            got = 32'({term2_oe, term2_oe & term2_out});
            check(got, 32'({route[11:8] == 4'h2, route[11:8] == 4'h2 && central_dma_request}));
            e = {!serial_latch_n && serial_data_oe, serial_data_out};
            got = 32'({term1_oe, term1_oe & term1_out});
            check(got, 32'({e[1], e[1] & e[0]}));
        end
        // Reset again with a live routing in place
        @(negedge ref_clk);
        sys_rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        check(32'({term_oe, term1_oe, term2_oe}), 32'h0);
        access(1'b0, 3'h0, 8'h8c, 4'h0, 32'h0);
        check(rd, 32'h0);
        stop_test();
    end
endmodule
